// >>> hdl/psc_top.sv
// Processor status and control register with reset cause, suspend and halt.
// Assumes CPU strobes are one-cycle pulses synchronous to i_sys_clk.
`timescale 1ns/100ps
`include "psc_map.svh"

module psc_top #(
	parameter logic [15:0] P_BUS_HOLD_CYC = 16'(`PSC_BUS_HOLD_CYC),
	parameter logic [23:0] P_WDT_CYC      = 24'(`PSC_WDT_CYC)
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_lvr_event,
	input  wire logic       i_wdt_clear,
	input  wire logic [7:0] i_io_addr,
	input  wire logic       i_io_wr,
	input  wire logic       i_io_rd,
	input  wire logic [7:0] i_io_wdata,
	input  wire logic       i_usb_ps2_mode,
	input  wire logic       i_usb_bus_reset,
	input  wire logic       i_ps2_activity,
	input  wire logic       i_irq_pending_any,
	input  wire logic       i_irq_service,
	input  wire logic       i_instr_di,
	input  wire logic       i_instr_ei,
	input  wire logic       i_instr_return_from_interrupt_instruction,
	input  wire logic       i_instr_halt,
	input  wire logic       i_resume_cond,
	output logic      [7:0] o_io_rdata,
	output logic            o_gie,
	output logic            o_cpu_stop,
	output logic            o_suspend,
	output logic            o_wdt_reset,
	output logic            o_pend_clear
);

	localparam logic [15:0] L_WAKE_CYC = 16'(`PSC_WAKE_CYC);
	localparam int          L_WAKE_MAX = `PSC_WAKE_CYC + 2;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	function automatic logic addr_hit(input logic [7:0] addr);
		addr_hit = (addr == `PSC_ADDR_STATUS);
	endfunction : addr_hit

	psc_pkg::psc_status_s status_r;
	psc_pkg::psc_status_s status_nxt;
	psc_pkg::psc_state_e  state_r;
	psc_pkg::psc_state_e  state_nxt;
	logic [15:0]          bus_cnt_r;
	logic [15:0]          bus_cnt_nxt;
	logic [23:0]          wdt_cnt_r;
	logic [23:0]          wdt_cnt_nxt;
	logic [15:0]          wake_cnt_r;
	logic [15:0]          wake_cnt_nxt;
	logic [7:0]           rdata_nxt;
	logic                 wr_hit;
	logic                 bus_cond;
	logic                 bus_fire;
	logic                 wdt_roll;

	assign wr_hit   = i_io_wr && addr_hit(i_io_addr);
	assign bus_cond = i_usb_ps2_mode ? i_ps2_activity : i_usb_bus_reset;
	assign bus_fire = bus_cond && (bus_cnt_r == P_BUS_HOLD_CYC - 16'h0001);
	assign wdt_roll = (wdt_cnt_r == P_WDT_CYC - 24'h00_0001);

	// ------------------------------------------------------------------
	// Qualifying and watchdog counters
	// ------------------------------------------------------------------
	always_comb begin
		bus_cnt_nxt = bus_cnt_r;
		if (!bus_cond) begin
			bus_cnt_nxt = '0;
		end else if (bus_cnt_r != P_BUS_HOLD_CYC) begin
			bus_cnt_nxt = bus_cnt_r + 16'h0001;
		end
		wdt_cnt_nxt = wdt_cnt_r + 24'h00_0001;
		if (i_wdt_clear || wdt_roll || i_lvr_event) begin
			wdt_cnt_nxt = '0;
		end else if (state_r == psc_pkg::ST_SUSP || state_r == psc_pkg::ST_WAKE) begin
			wdt_cnt_nxt = wdt_cnt_r;
		end
	end

	// ------------------------------------------------------------------
	// Status register and run state
	// ------------------------------------------------------------------
	always_comb begin
		status_nxt      = status_r;
		state_nxt       = state_r;
		wake_cnt_nxt    = wake_cnt_r;
		status_nxt.pend = i_irq_pending_any;
		if (wr_hit) begin
			status_nxt.watchdog_reset_event     = i_io_wdata[`PSC_BIT_WDR];
			status_nxt.bus_evt = i_io_wdata[`PSC_BIT_BUS];
			status_nxt.low_voltage_reset_event     = i_io_wdata[`PSC_BIT_LVR];
			status_nxt.susp    = i_io_wdata[`PSC_BIT_SUSP];
			status_nxt.run     = i_io_wdata[`PSC_BIT_RUN];
		end
		if (bus_fire) begin
			status_nxt.bus_evt = 1'b1;
		end
		if (i_instr_di) begin
			status_nxt.gie = 1'b0;
		end
		if (i_instr_ei || i_instr_return_from_interrupt_instruction) begin
			status_nxt.gie = 1'b1;
		end
		if (i_irq_service) begin
			status_nxt.gie = 1'b0;
		end
		unique case (state_r)
			psc_pkg::ST_RUN: begin
				if (wr_hit && i_io_wdata[`PSC_BIT_SUSP]) begin
					state_nxt = psc_pkg::ST_SUSP;
				end
			end
			psc_pkg::ST_SUSP: begin
				if (i_resume_cond) begin
					state_nxt    = psc_pkg::ST_WAKE;
					wake_cnt_nxt = '0;
				end
			end
			psc_pkg::ST_WAKE: begin
				wake_cnt_nxt = wake_cnt_r + 16'h0001;
				if (wake_cnt_r == L_WAKE_CYC - 16'h0001) begin
					state_nxt       = psc_pkg::ST_RUN;
					status_nxt.susp = 1'b0;
				end
			end
			psc_pkg::ST_HALT: begin
				state_nxt = psc_pkg::ST_HALT;
			end
		endcase
		if (i_instr_halt && state_r == psc_pkg::ST_RUN) begin
			status_nxt.run = 1'b0;
			state_nxt      = psc_pkg::ST_HALT;
		end
		if (i_lvr_event) begin
			status_nxt   = psc_pkg::psc_status_s'(`PSC_RST_POR);
			state_nxt    = psc_pkg::ST_RUN;
			wake_cnt_nxt = '0;
		end else if (wdt_roll) begin
			status_nxt.pend = 1'b0;
			status_nxt.watchdog_reset_event  = 1'b1;
			status_nxt.low_voltage_reset_event  = status_r.low_voltage_reset_event;
			status_nxt.bus_evt = status_r.bus_evt || bus_fire;
			status_nxt.susp = 1'b0;
			status_nxt.gie  = 1'b0;
			status_nxt.rsvd = 1'b0;
			status_nxt.run  = 1'b1;
			state_nxt       = psc_pkg::ST_RUN;
			wake_cnt_nxt    = '0;
		end
		rdata_nxt = 8'h00;
		if (i_io_rd && addr_hit(i_io_addr)) begin
			rdata_nxt = status_r;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			status_r     <= psc_pkg::psc_status_s'(`PSC_RST_POR);
			state_r      <= psc_pkg::ST_RUN;
			bus_cnt_r    <= '0;
			wdt_cnt_r    <= '0;
			wake_cnt_r   <= '0;
			o_io_rdata   <= 8'h00;
			o_gie        <= 1'b0;
			o_cpu_stop   <= 1'b0;
			o_suspend    <= 1'b0;
			o_wdt_reset  <= 1'b0;
			o_pend_clear <= 1'b0;
		end else begin
			status_r     <= status_nxt;
			state_r      <= state_nxt;
			bus_cnt_r    <= bus_cnt_nxt;
			wdt_cnt_r    <= wdt_cnt_nxt;
			wake_cnt_r   <= wake_cnt_nxt;
			o_io_rdata   <= rdata_nxt;
			o_gie        <= status_nxt.gie;
			o_cpu_stop   <= (state_nxt != psc_pkg::ST_RUN);
			o_suspend    <= (state_nxt == psc_pkg::ST_SUSP);
			o_wdt_reset  <= wdt_roll && !i_lvr_event;
			o_pend_clear <= i_irq_service;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);

	a_pend_mirror: assert property (
		!i_lvr_event && !wdt_roll |=> status_r.pend == $past(i_irq_pending_any))
		else $error("pending flag does not follow pending interrupts");

	a_wdt_fire: assert property (
		wdt_roll && !i_lvr_event |=> o_wdt_reset && status_r.watchdog_reset_event)
		else $error("watchdog rollover gave no watchdog reset");

	a_wdr_load: assert property (
		wdt_roll && !i_lvr_event |=> !status_r.pend && status_r.run && !status_r.susp
			&& status_r.low_voltage_reset_event == $past(status_r.low_voltage_reset_event)
			&& status_r.bus_evt == ($past(status_r.bus_evt) || $past(bus_fire)))
		else $error("watchdog reset loaded a wrong status value");

	a_lvr_load: assert property (
		i_lvr_event |=> status_r == psc_pkg::psc_status_s'(`PSC_RST_POR) && !o_gie)
		else $error("low-voltage reset loaded a wrong status value");

	a_bus_mode: assert property (
		(i_usb_ps2_mode ? !i_ps2_activity : !i_usb_bus_reset) |=> bus_cnt_r == 16'h0000)
		else $error("bus qualifier counted the unselected source");

	a_bus_set: assert property (
		bus_fire && !i_lvr_event |=> status_r.bus_evt)
		else $error("bus event bit missed a qualified event");

	a_bus_sticky: assert property (
		status_r.bus_evt && !wr_hit && !i_lvr_event |=> status_r.bus_evt)
		else $error("bus event bit cleared without write or reset");

	a_susp_enter: assert property (
		state_r == psc_pkg::ST_RUN && wr_hit && i_io_wdata[`PSC_BIT_SUSP]
			&& !i_instr_halt && !i_lvr_event && !wdt_roll
			|=> o_suspend && o_cpu_stop && status_r.susp)
		else $error("suspend write did not enter suspend");

	a_wake_bound: assert property (
		state_r == psc_pkg::ST_SUSP && i_resume_cond
			|-> ##[1:L_WAKE_MAX] (state_r == psc_pkg::ST_RUN))
		else $error("wake-up did not finish in time");

	a_susp_clear: assert property (
		state_r == psc_pkg::ST_WAKE && state_nxt == psc_pkg::ST_RUN |=> !status_r.susp && !o_cpu_stop)
		else $error("suspend bit still set after resume");

	a_gie_ignore_wr: assert property (
		!i_instr_di && !i_instr_ei && !i_instr_return_from_interrupt_instruction && !i_irq_service
			&& !i_lvr_event && !wdt_roll |=> $stable(o_gie) && o_gie == status_r.gie)
		else $error("interrupt enable sense changed without instruction");

	a_halt_stays: assert property (
		state_r == psc_pkg::ST_HALT && !i_lvr_event && !wdt_roll
			|=> state_r == psc_pkg::ST_HALT && o_cpu_stop)
		else $error("halted processor restarted without reset");

	a_halt_clr: assert property (
		state_r == psc_pkg::ST_RUN && i_instr_halt && !i_lvr_event && !wdt_roll
			|=> !status_r.run && o_cpu_stop)
		else $error("halt did not clear run");

	a_service: assert property (
		i_irq_service && !i_instr_ei && !i_instr_return_from_interrupt_instruction |=> !o_gie && o_pend_clear)
		else $error("service did not disable then clear pending");

	a_return_from_interrupt_instruction: assert property (
		i_instr_return_from_interrupt_instruction && !i_irq_service && !i_lvr_event && !wdt_roll |=> o_gie)
		else $error("return from interrupt did not re-enable");

	a_wdt_pulse: assert property (
		o_wdt_reset |=> !o_wdt_reset)
		else $error("watchdog reset pulse lasted more than one cycle");

	a_rd_return: assert property (
		i_io_rd && addr_hit(i_io_addr) |=> o_io_rdata == $past(status_r))
		else $error("status read returned a wrong value");

	c_wake: cover property (state_r == psc_pkg::ST_WAKE ##1 state_r == psc_pkg::ST_RUN);
	c_halt: cover property (state_r == psc_pkg::ST_HALT ##1 state_r == psc_pkg::ST_RUN);
	c_bus:  cover property (bus_fire);
	c_wdr:  cover property (o_wdt_reset && status_r.low_voltage_reset_event);
	c_susp_now: cover property (state_r == psc_pkg::ST_SUSP && i_resume_cond);

endmodule : psc_top

// >>> common/psc_map.svh
// Offsets, field positions, reset values and timing counts of the status block.
// Assumes the includer is compiled after this header; definitions only.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// ----------------------------------------------------------------------
// Register address and field positions
// ----------------------------------------------------------------------
`define PSC_ADDR_STATUS 8'hFF
`define PSC_BIT_PEND    7
`define PSC_BIT_WDR     6
`define PSC_BIT_BUS     5
`define PSC_BIT_LVR     4
`define PSC_BIT_SUSP    3
`define PSC_BIT_GIE     2
`define PSC_BIT_RUN     0

// ----------------------------------------------------------------------
// Reset value
// ----------------------------------------------------------------------
`define PSC_RST_POR     8'h11

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PSC_CLK_MHZ     200
`define PSC_BUS_HOLD_US 128
`define PSC_BUS_HOLD_CYC (`PSC_BUS_HOLD_US * `PSC_CLK_MHZ)
`define PSC_WDT_CYC     65536
`define PSC_WAKE_CYC    64

`endif

// >>> common/psc_pkg.sv
// Types shared by the processor status and control block.
// Assumes psc_map.svh for the numeric layout.
package psc_pkg;

	// ------------------------------------------------------------------
	// Status register layout, bit 7 first
	// ------------------------------------------------------------------
	typedef struct packed {
		logic pend;
		logic watchdog_reset_event;
		logic bus_evt;
		logic low_voltage_reset_event;
		logic susp;
		logic gie;
		logic rsvd;
		logic run;
	} psc_status_s;

	// ------------------------------------------------------------------
	// Processor power and run state
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_SUSP = 2'b01,
		ST_WAKE = 2'b10,
		ST_HALT = 2'b11
	} psc_state_e;

endpackage : psc_pkg

// >>> dv/tb_top.sv
// Self-checking bench for the processor status and control block.
// Assumes psc_top with short bus-hold and watchdog counts set below.
`timescale 1ns/100ps
`include "psc_map.svh"

module tb_top;
	logic       i_sys_clk, i_rstn, i_lvr_event, i_wdt_clear, i_io_wr, i_io_rd;
	logic [7:0] i_io_addr, i_io_wdata, o_io_rdata, d;
	logic       i_usb_ps2_mode, i_usb_bus_reset, i_ps2_activity, i_irq_pending_any;
	logic       i_irq_service, i_instr_di, i_instr_ei, i_instr_return_from_interrupt_instruction, i_instr_halt;
	logic       i_resume_cond, o_gie, o_cpu_stop, o_suspend, o_wdt_reset, o_pend_clear;
	logic       rd_hit;
	logic [7:0] exp_q[$];
	int         failures, check_count, n;
	integer     seed;

	psc_top #(.P_BUS_HOLD_CYC(16'h0008), .P_WDT_CYC(24'h00_0040)) dut_u (
		.i_sys_clk, .i_rstn, .i_lvr_event, .i_wdt_clear, .i_io_addr, .i_io_wr,
		.i_io_rd, .i_io_wdata, .i_usb_ps2_mode, .i_usb_bus_reset, .i_ps2_activity,
		.i_irq_pending_any, .i_irq_service, .i_instr_di, .i_instr_ei, .i_instr_return_from_interrupt_instruction,
		.i_instr_halt, .i_resume_cond, .o_io_rdata, .o_gie, .o_cpu_stop, .o_suspend,
		.o_wdt_reset, .o_pend_clear);

	// ------------------------------------------------------------------
	// Clock, checks and closing
	// ------------------------------------------------------------------
	initial begin
		i_sys_clk = 1'b0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	// Read results pair with the oldest note
	always @(posedge i_sys_clk) rd_hit <= i_io_rd;
	always @(negedge i_sys_clk) begin
		if (rd_hit)
			check("rdata", exp_q.pop_front(), o_io_rdata);
	end

	initial begin
		#(20000 * 5);
		failures++;
		summarize();
	end

	// ------------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------------
	task automatic tick(input int k = 1);
		repeat (k) @(negedge i_sys_clk);
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		i_io_addr  = a;
		i_io_wdata = v;
		i_io_wr    = 1'b1;
		tick();
		i_io_wr    = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_io_addr = a;
		i_io_rd   = 1'b1;
		exp_q.push_back(e);
		tick();
		i_io_rd   = 1'b0;
		tick();
	endtask : rd

	task automatic wake_wait;
		n = 0;
		while (o_cpu_stop !== 1'b0 && n < 100) begin
			tick();
			n++;
		end
	endtask : wake_wait

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		{i_lvr_event, i_io_wr, i_io_rd, i_usb_ps2_mode, i_usb_bus_reset} = '0;
		{i_ps2_activity, i_irq_pending_any, i_irq_service, i_instr_di} = '0;
		{i_instr_ei, i_instr_return_from_interrupt_instruction, i_instr_halt, i_resume_cond} = '0;
		{i_io_addr, i_io_wdata} = '0;
		i_wdt_clear = 1'b1;
		seed = 32'h7555;
		i_rstn = 1'b0;
		tick(3);
		i_rstn = 1'b1;
		rd(8'hFF, 8'h11);
		wr(8'hFF, 8'hF5);
		rd(8'hFF, 8'h71);
		wr(8'hFF, 8'h01);
		rd(8'hFF, 8'h01);
		wr(8'h20, 8'h79);
		rd(8'h20, 8'h00);
		rd(8'hFF, 8'h01);
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			d = (d & 8'hF5) | 8'h01;
			wr(8'hFF, d);
			rd(8'hFF, d & 8'h71);
		end
		wr(8'hFF, 8'h01);
		// Interrupt enable sense and servicing
		i_instr_ei = 1'b1; tick(); i_instr_ei = 1'b0;
		rd(8'hFF, 8'h05);
		i_instr_di = 1'b1; tick(); i_instr_di = 1'b0;
		check("gie_di", 8'h00, {7'h00, o_gie});
		i_instr_return_from_interrupt_instruction = 1'b1; tick(); i_instr_return_from_interrupt_instruction = 1'b0;
		check("gie_return_from_interrupt_instruction", 8'h01, {7'h00, o_gie});
		i_irq_service = 1'b1; tick(); i_irq_service = 1'b0;
		check("svc", 8'h01, {6'h00, o_gie, o_pend_clear});
		tick();
		check("pclr", 8'h00, {7'h00, o_pend_clear});
		i_irq_pending_any = 1'b1;
		tick();
		rd(8'hFF, 8'h81);
		i_irq_pending_any = 1'b0;
		// Bus event source and hold time
		i_usb_bus_reset = 1'b1; tick(7); i_usb_bus_reset = 1'b0;
		rd(8'hFF, 8'h01);
		i_usb_ps2_mode = 1'b1;
		i_usb_bus_reset = 1'b1; tick(12); i_usb_bus_reset = 1'b0;
		rd(8'hFF, 8'h01);
		i_ps2_activity = 1'b1; tick(12); i_ps2_activity = 1'b0;
		rd(8'hFF, 8'h21);
		rd(8'hFF, 8'h21);
		wr(8'hFF, 8'h01);
		rd(8'hFF, 8'h01);
		i_usb_ps2_mode = 1'b0;
		i_usb_bus_reset = 1'b1; tick(12); i_usb_bus_reset = 1'b0;
		rd(8'hFF, 8'h21);
		// Halt, then watchdog roll
		wr(8'hFF, 8'h31);
		i_instr_halt = 1'b1; tick(); i_instr_halt = 1'b0;
		check("halt", 8'h01, {7'h00, o_cpu_stop});
		rd(8'hFF, 8'h30);
		i_instr_ei = 1'b1; tick(); i_instr_ei = 1'b0;
		check("halt_irq", 8'h01, {7'h00, o_cpu_stop});
		i_wdt_clear = 1'b0;
		n = 0;
		while (o_wdt_reset !== 1'b1 && n < 200) begin
			tick();
			n++;
		end
		check("wdt_pulse", 8'h01, {7'h00, o_wdt_reset});
		check("wdt_cycles", 8'h40, 8'(n));
		tick();
		i_wdt_clear = 1'b1;
		check("wdt_run", 8'h00, {6'h00, o_wdt_reset, o_cpu_stop});
		rd(8'hFF, 8'h71);
		i_lvr_event = 1'b1; tick(); i_lvr_event = 1'b0;
		rd(8'hFF, 8'h11);
		i_wdt_clear = 1'b0;
		tick(70);
		i_wdt_clear = 1'b1;
		rd(8'hFF, 8'h51);
		// Suspend and resume
		wr(8'hFF, 8'h09);
		check("susp", 8'h03, {6'h00, o_suspend, o_cpu_stop});
		tick(5);
		check("susp_hold", 8'h03, {6'h00, o_suspend, o_cpu_stop});
		i_resume_cond = 1'b1; tick(); i_resume_cond = 1'b0;
		check("wake", 8'h01, {6'h00, o_suspend, o_cpu_stop});
		wake_wait();
		check("woke", 8'h00, {7'h00, o_cpu_stop});
		rd(8'hFF, 8'h01);
		i_resume_cond = 1'b1;
		wr(8'hFF, 8'h01);
		tick();
		wr(8'hFF, 8'h09);
		check("susp_now", 8'h01, {7'h00, o_suspend});
		tick();
		i_resume_cond = 1'b0;
		check("wake_now", 8'h01, {6'h00, o_suspend, o_cpu_stop});
		wake_wait();
		rd(8'hFF, 8'h01);
		summarize();
	end
endmodule : tb_top
